// ### common/csr_pkg.sv
// package for the core status and reset-cause flag block
// assumes a single core clock and a byte-wide register port
package csr_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [8:0] POWER_CONTROL_OFFSET = 9'h08e;
    localparam logic [8:0] CORE_STATUS_OFFSET   = 9'h003;
    localparam logic [8:0] BANK_STRIDE          = 9'h080;

    // ------------------------------------------------------------
    // core status field positions
    // ------------------------------------------------------------
    localparam int CARRY_POS      = 0;
    localparam int NIBBLE_POS     = 1;
    localparam int ZERO_POS       = 2;
    localparam int SLEEP_POS      = 3;
    localparam int WATCHDOG_POS   = 4;
    localparam int BANK_LO_POS    = 5;
    localparam int BANK_HI_POS    = 6;
    localparam int INDIRECT_POS   = 7;

    // ------------------------------------------------------------
    // power control field positions
    // ------------------------------------------------------------
    localparam int BROWNOUT_POS   = 0;
    localparam int POWERON_POS    = 1;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] CORE_STATUS_RESET   = 8'h18;
    localparam logic [1:0] POWER_CONTROL_RESET = 2'h1;
    localparam logic [1:0] POWER_CONTROL_MASK  = 2'h3;

    // ------------------------------------------------------------
    // alu operations
    // ------------------------------------------------------------
    typedef enum logic [3:0]
    {
        CSR_OP_NONE,
        CSR_OP_ADD,
        CSR_OP_SUB,
        CSR_OP_AND,
        CSR_OP_OR,
        CSR_OP_XOR,
        CSR_OP_INC,
        CSR_OP_DEC,
        CSR_OP_COMPLEMENT,
        CSR_OP_MOVE_FILE,
        CSR_OP_CLEAR_FILE,
        CSR_OP_ROTATE_RIGHT,
        CSR_OP_ROTATE_LEFT,
        CSR_OP_BIT_CLEAR,
        CSR_OP_BIT_SET,
        CSR_OP_NIBBLE_SWAP
    } csr_op_type;

endpackage

// ### logic/csr_alu.sv
// arithmetic unit that produces a result and the three arithmetic flags
// assumes operands are presented and read in the same cycle
`timescale 1ns/1ps

module csr_alu
    import csr_pkg::*;
(
    input  wire csr_op_type op,
    input  wire logic [7:0] work_value,
    input  wire logic [7:0] file_value,
    input  wire logic [2:0] bit_select,
    input  wire logic       carry_in,
    output logic      [7:0] result,
    output logic            carry_out,
    output logic            nibble_out,
    output logic            zero_out,
    output logic            affects_zero,
    output logic            affects_carry
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [8:0] add9(input logic [7:0] a,
                                        input logic [7:0] b,
                                        input logic       cin);
        add9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    endfunction

    function automatic logic [4:0] add5(input logic [3:0] a,
                                        input logic [3:0] b,
                                        input logic       cin);
        add5 = {1'b0, a} + {1'b0, b} + {4'h0, cin};
    endfunction

    logic [8:0] sum;
    logic [4:0] low_sum;

    always_comb
    begin
        sum           = 9'h000;
        low_sum       = 5'h00;
        result        = file_value;
        carry_out     = carry_in;
        nibble_out    = 1'b0;
        affects_zero  = 1'b0;
        affects_carry = 1'b0;
        case (op)
            CSR_OP_ADD:
            begin
                sum           = add9(file_value, work_value, 1'b0);
                low_sum       = add5(file_value[3:0], work_value[3:0], 1'b0);
                result        = sum[7:0];
                carry_out     = sum[8];
                nibble_out    = low_sum[4];
                affects_zero  = 1'b1;
                affects_carry = 1'b1;
            end
            CSR_OP_SUB:
            begin
                sum           = add9(file_value, ~work_value, 1'b1);
                low_sum       = add5(file_value[3:0], ~work_value[3:0], 1'b1);
                result        = sum[7:0];
                carry_out     = sum[8];
                nibble_out    = low_sum[4];
                affects_zero  = 1'b1;
                affects_carry = 1'b1;
            end
            CSR_OP_AND:
            begin
                result       = file_value & work_value;
                affects_zero = 1'b1;
            end
            CSR_OP_OR:
            begin
                result       = file_value | work_value;
                affects_zero = 1'b1;
            end
            CSR_OP_XOR:
            begin
                result       = file_value ^ work_value;
                affects_zero = 1'b1;
            end
            CSR_OP_INC:
            begin
                result       = file_value + 8'h01;
                affects_zero = 1'b1;
            end
            CSR_OP_DEC:
            begin
                result       = file_value - 8'h01;
                affects_zero = 1'b1;
            end
            CSR_OP_COMPLEMENT:
            begin
                result       = ~file_value;
                affects_zero = 1'b1;
            end
            CSR_OP_MOVE_FILE:
            begin
                result       = work_value;
            end
            CSR_OP_CLEAR_FILE:
            begin
                result       = 8'h00;
                affects_zero = 1'b1;
            end
            CSR_OP_ROTATE_RIGHT:
            begin
                result        = {carry_in, file_value[7:1]};
                carry_out     = file_value[0];
                affects_carry = 1'b1;
            end
            CSR_OP_ROTATE_LEFT:
            begin
                result        = {file_value[6:0], carry_in};
                carry_out     = file_value[7];
                affects_carry = 1'b1;
            end
            CSR_OP_BIT_CLEAR:
            begin
                result             = file_value;
                result[bit_select] = 1'b0;
            end
            CSR_OP_BIT_SET:
            begin
                result             = file_value;
                result[bit_select] = 1'b1;
            end
            CSR_OP_NIBBLE_SWAP:
            begin
                result = {file_value[3:0], file_value[7:4]};
            end
            default:
            begin
                result = file_value;
            end
        endcase
        zero_out = (result == 8'h00);
    end

endmodule

// ### logic/csr_flags.sv
// core status and reset-cause flag registers
// assumes the core issues one operation per cycle and owns the
// reset sources as synchronous one-cycle event pulses
//
// The plain strobed port was left to the implementer.
`timescale 1ns/1ps

module csr_flags
    import csr_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       op_valid,
    input  wire csr_op_type op,
    input  wire logic [8:0] dest_addr,
    input  wire logic [7:0] work_value,
    input  wire logic [7:0] file_value,
    input  wire logic [2:0] bit_select,
    input  wire logic       poweron_event,
    input  wire logic       brownout_event,
    input  wire logic       watchdog_expiry,
    input  wire logic       watchdog_kick_op,
    input  wire logic       sleep_op,
    input  wire logic       brownout_detect_enable,
    input  wire logic [8:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_write,
    input  wire logic       reg_read,
    output logic      [7:0] reg_rdata,
    output logic      [7:0] op_result,
    output logic      [7:0] core_status,
    output logic      [1:0] power_control_flags,
    output logic      [1:0] direct_bank,
    output logic            indirect_page_bit,
    output logic            brownout_valid
);

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function automatic logic is_status(input logic [8:0] addr);
        is_status = (addr[6:0] == CORE_STATUS_OFFSET[6:0]);
    endfunction

    function automatic logic is_power(input logic [8:0] addr);
        is_power = (addr == POWER_CONTROL_OFFSET);
    endfunction

    // ------------------------------------------------------------
    // arithmetic unit
    // ------------------------------------------------------------
    logic [7:0] alu_result;
    logic       alu_carry;
    logic       alu_nibble;
    logic       alu_zero;
    logic       alu_affects_zero;
    logic       alu_affects_carry;

    csr_alu u_alu
    (
        .op            (op),
        .work_value    (work_value),
        .file_value    (file_value),
        .bit_select    (bit_select),
        .carry_in      (core_status[CARRY_POS]),
        .result        (alu_result),
        .carry_out     (alu_carry),
        .nibble_out    (alu_nibble),
        .zero_out      (alu_zero),
        .affects_zero  (alu_affects_zero),
        .affects_carry (alu_affects_carry)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    logic [7:0] next_core_status;
    logic [1:0] next_power_control_flags;
    logic [7:0] next_reg_rdata;
    logic [7:0] next_op_result;
    logic [1:0] next_direct_bank;
    logic       next_indirect_page_bit;
    logic       next_brownout_valid;
    logic       op_to_status;
    logic       op_to_power;
    logic       sw_to_status;
    logic       sw_to_power;
    logic [7:0] write_value;

    always_comb
    begin
        next_core_status         = core_status;
        next_power_control_flags = power_control_flags;
        op_to_status             = op_valid && (op != CSR_OP_NONE)
                                   && is_status(dest_addr);
        op_to_power              = op_valid && (op != CSR_OP_NONE)
                                   && is_power(dest_addr);
        sw_to_status             = reg_write && is_status(reg_addr);
        sw_to_power              = reg_write && is_power(reg_addr);
        write_value              = op_to_status ? alu_result : reg_wdata;

        if (op_to_status || sw_to_status)
        begin
            next_core_status[INDIRECT_POS] = write_value[INDIRECT_POS];
            next_core_status[BANK_HI_POS]  = write_value[BANK_HI_POS];
            next_core_status[BANK_LO_POS]  = write_value[BANK_LO_POS];
        end
        if (op_to_status ? !(alu_affects_zero || alu_affects_carry)
                         : sw_to_status)
        begin
            next_core_status[ZERO_POS]     = write_value[ZERO_POS];
            next_core_status[NIBBLE_POS]   = write_value[NIBBLE_POS];
            next_core_status[CARRY_POS]    = write_value[CARRY_POS];
        end

        if (op_valid && alu_affects_zero)
        begin
            next_core_status[ZERO_POS] = alu_zero;
        end
        if (op_valid && alu_affects_carry)
        begin
            next_core_status[CARRY_POS] = alu_carry;
        end
        if (op_valid && (op == CSR_OP_ADD || op == CSR_OP_SUB))
        begin
            next_core_status[NIBBLE_POS] = alu_nibble;
        end

        if (watchdog_kick_op)
        begin
            next_core_status[WATCHDOG_POS] = 1'b1;
            next_core_status[SLEEP_POS]    = 1'b1;
        end
        if (sleep_op)
        begin
            next_core_status[WATCHDOG_POS] = 1'b1;
            next_core_status[SLEEP_POS]    = 1'b0;
        end
        if (watchdog_expiry)
        begin
            next_core_status[WATCHDOG_POS] = 1'b0;
        end

        // software sets the cause flags
        if (op_to_power)
        begin
            next_power_control_flags = alu_result[1:0];
        end
        else if (sw_to_power)
        begin
            next_power_control_flags = reg_wdata[1:0];
        end

        if (poweron_event)
        begin
            next_power_control_flags[POWERON_POS] = 1'b0;
            next_core_status                      = CORE_STATUS_RESET;
        end
        if (brownout_event)
        begin
            next_power_control_flags[BROWNOUT_POS] = 1'b0;
            next_core_status                       = CORE_STATUS_RESET;
        end

        next_direct_bank       = next_core_status[BANK_HI_POS:BANK_LO_POS];
        next_indirect_page_bit = next_core_status[INDIRECT_POS];
        next_brownout_valid    = brownout_detect_enable;

        next_op_result = op_valid ? alu_result : op_result;

        next_reg_rdata = 8'h00;
        if (reg_read && is_status(reg_addr))
        begin
            next_reg_rdata = core_status;
        end
        else if (reg_read && is_power(reg_addr))
        begin
            next_reg_rdata = {6'h00, power_control_flags};
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            core_status         <= CORE_STATUS_RESET;
            power_control_flags <= POWER_CONTROL_RESET;
            reg_rdata           <= 8'h00;
            op_result           <= 8'h00;
            direct_bank         <= 2'h0;
            indirect_page_bit   <= 1'b0;
            brownout_valid      <= 1'b0;
        end
        else
        begin
            core_status         <= next_core_status;
            power_control_flags <= next_power_control_flags;
            reg_rdata           <= next_reg_rdata;
            op_result           <= next_op_result;
            direct_bank         <= next_direct_bank;
            indirect_page_bit   <= next_indirect_page_bit;
            brownout_valid      <= next_brownout_valid;
        end
    end

endmodule

// ### sim/csr_flags_asserts.sv
// checker for the core status and reset-cause flag block
// bound to csr_flags; sees only its ports, single clock domain
`timescale 1ns/1ps

module csr_flags_asserts
    import csr_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       op_valid,
    input wire csr_op_type op,
    input wire logic [8:0] dest_addr,
    input wire logic [7:0] work_value,
    input wire logic [7:0] file_value,
    input wire logic       poweron_event,
    input wire logic       brownout_event,
    input wire logic       watchdog_expiry,
    input wire logic       watchdog_kick_op,
    input wire logic       sleep_op,
    input wire logic [8:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_write,
    input wire logic       reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] op_result,
    input wire logic [7:0] core_status,
    input wire logic [1:0] power_control_flags
);
    // ------------------------------------------------------------
    // helpers and properties
    // ------------------------------------------------------------
    wire       quiet   = !(poweron_event | brownout_event | watchdog_expiry
                         | watchdog_kick_op | sleep_op);
    wire       st_dest = dest_addr[6:0] == CORE_STATUS_OFFSET[6:0];
    wire       st_reg  = reg_addr[6:0] == CORE_STATUS_OFFSET[6:0];
    wire [8:0] add_sum = {1'b0, work_value} + {1'b0, file_value};
    wire [4:0] nib_sum = {1'b0, work_value[3:0]} + {1'b0, file_value[3:0]};

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence s_sw_status;
        reg_write && st_reg && quiet && !op_valid;
    endsequence
    sequence s_op(k, d);
        op_valid && op == k && st_dest == d && quiet;
    endsequence

    property p_status_read;
        reg_read && st_reg |=> reg_rdata == $past(core_status);
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read data wrong");
    property p_power_read;
        reg_read && reg_addr == POWER_CONTROL_OFFSET
            |=> reg_rdata == {6'h00, $past(power_control_flags)};
    endproperty
    a_power_read: assert property (p_power_read)
        else $error("power flag read data wrong");
    property p_sw_write;
        s_sw_status |=> core_status[7:5] == $past(reg_wdata[7:5])
            && core_status[2:0] == $past(reg_wdata[2:0]);
    endproperty
    a_sw_write: assert property (p_sw_write)
        else $error("status write not taken");
    property p_sw_locked;
        s_sw_status |=> $stable(core_status[4:3]);
    endproperty
    a_sw_locked: assert property (p_sw_locked)
        else $error("timeout or sleep bit written");
    property p_clear;
        s_op(CSR_OP_CLEAR_FILE, 1'b1) |=> core_status[7:5] == 3'h0
            && core_status[2] && $stable(core_status[1:0]);
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear of status wrong");
    property p_flags_kept;
        op_valid && quiet && !st_dest && !reg_write && op inside
            {CSR_OP_BIT_CLEAR, CSR_OP_BIT_SET, CSR_OP_NIBBLE_SWAP,
             CSR_OP_MOVE_FILE} |=> $stable(core_status[2:0]);
    endproperty
    a_flags_kept: assert property (p_flags_kept)
        else $error("flags changed by bit or move op");
    property p_add;
        s_op(CSR_OP_ADD, 1'b0) |=> op_result == $past(add_sum[7:0])
            && core_status[0] == $past(add_sum[8])
            && core_status[1] == $past(nib_sum[4])
            && core_status[2] == ($past(add_sum[7:0]) == 8'h00);
    endproperty
    a_add: assert property (p_add)
        else $error("add result or flags wrong");
    property p_poweron;
        poweron_event |=> !power_control_flags[POWERON_POS]
            && core_status == CORE_STATUS_RESET;
    endproperty
    a_poweron: assert property (p_poweron)
        else $error("power-on event not recorded");
    property p_brownout;
        brownout_event && !poweron_event
            |=> power_control_flags == ($past(power_control_flags) & 2'h2);
    endproperty
    a_brownout: assert property (p_brownout)
        else $error("brownout event not recorded");
    property p_expiry;
        watchdog_expiry && !poweron_event && !brownout_event
            |=> !core_status[WATCHDOG_POS];
    endproperty
    a_expiry: assert property (p_expiry)
        else $error("watchdog expiry not recorded");
endmodule

bind csr_flags csr_flags_asserts u_asserts (.*);

// ### sim/csr_core_model.sv
// model of the core side: alu operations and reset-source pulses
// drives csr_flags inputs just after rising edges of clk
`timescale 1ns/1ps

module csr_core_model
    import csr_pkg::*;
(
    input  wire logic  clk,
    output logic       op_valid,
    output csr_op_type op,
    output logic [8:0] dest_addr,
    output logic [7:0] work_value,
    output logic [7:0] file_value,
    output logic [2:0] bit_select,
    output logic       poweron_event,
    output logic       brownout_event,
    output logic       watchdog_expiry,
    output logic       watchdog_kick_op,
    output logic       sleep_op
);
    // ------------------------------------------------------------
    // operation and event tasks
    // ------------------------------------------------------------
    initial
    begin
        op_valid = 1'b0;
        op = CSR_OP_NONE;
        dest_addr = 9'h000;
        {work_value, file_value} = 16'h0000;
        bit_select = 3'h0;
        {poweron_event, brownout_event, watchdog_expiry} = 3'h0;
        {watchdog_kick_op, sleep_op} = 2'h0;
    end

    task automatic issue(input csr_op_type k, input logic [8:0] d,
                         input logic [7:0] w, f, input logic [2:0] b);
        @(posedge clk);
        op_valid   <= 1'b1;
        op         <= k;
        dest_addr  <= d;
        work_value <= w;
        file_value <= f;
        bit_select <= b;
        @(posedge clk);
        // operands are not held once the operation is gone
        op_valid   <= 1'b0;
        work_value <= ~w;
        file_value <= ~f;
        #1;
    endtask

    task automatic pulse(input logic [4:0] m);
        @(posedge clk);
        {poweron_event, brownout_event, watchdog_expiry,
         watchdog_kick_op, sleep_op} <= m;
        @(posedge clk);
        {poweron_event, brownout_event, watchdog_expiry,
         watchdog_kick_op, sleep_op} <= 5'h00;
        #1;
    endtask
endmodule

// ### sim/core_status_reset_flags_bench.sv
// self-checking bench for the core status and reset-cause flags
// drives the register port itself; core side is csr_core_model
`timescale 1ns/1ps

module core_status_reset_flags_bench
    import csr_pkg::*;
;
    logic       clk, rst_n, op_valid, poweron_event, brownout_event;
    logic       watchdog_expiry, watchdog_kick_op, sleep_op, reg_write;
    logic       brownout_detect_enable, reg_read, indirect_page_bit;
    logic       brownout_valid;
    csr_op_type op;
    logic [8:0] dest_addr, reg_addr;
    logic [7:0] work_value, file_value, reg_wdata, reg_rdata, op_result;
    logic [7:0] core_status;
    logic [2:0] bit_select;
    logic [1:0] power_control_flags, direct_bank;
    int         num_errors, num_checks, cycles;

    csr_flags      u_dut  (.*);
    csr_core_model u_core (.*);

    always #2.5 clk = ~clk;

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] seen, exp);
        num_checks++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [8:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        check("reg_rdata", reg_rdata, exp);
    endtask

    task automatic arith(input csr_op_type k, input logic [7:0] w, f, r,
                         input logic [2:0] m, x);
        u_core.issue(k, 9'h020, w, f, 3'h0);
        check("op_result", op_result, r);
        check("flags", {5'h00, core_status[2:0] & m}, {5'h00, x});
    endtask

    task automatic close_out;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            num_errors++;
            close_out();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        {clk, rst_n, reg_write, reg_read, brownout_detect_enable} = 5'h00;
        reg_addr = 9'h000;
        reg_wdata = 8'h00;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        check("core_status", core_status, 8'h18);
        check("power_flags", power_control_flags, 8'h01);
        rd(9'h003, 8'h18);
        rd(9'h010, 8'h00);
        wr(9'h003, 8'h00);
        check("core_status", core_status, 8'h18);
        wr(9'h083, 8'he7);
        check("core_status", core_status, 8'hff);
        check("banks", {indirect_page_bit, direct_bank}, 8'h07);
        wr(9'h003, 8'he3);
        u_core.issue(CSR_OP_CLEAR_FILE, 9'h003, 8'h00, 8'hfb, 3'h0);
        check("core_status", core_status, 8'h1f);
        u_core.issue(CSR_OP_ADD, 9'h003, 8'h80, 8'h80, 3'h0);
        check("core_status", core_status, 8'h1d);
        u_core.issue(CSR_OP_ADD, 9'h183, 8'he0, 8'h00, 3'h0);
        check("core_status", core_status, 8'hf8);
        arith(CSR_OP_ADD, 8'hf0, 8'h20, 8'h10, 3'h7, 3'h1);
        arith(CSR_OP_ADD, 8'h0f, 8'h01, 8'h10, 3'h7, 3'h2);
        arith(CSR_OP_ADD, 8'h80, 8'h80, 8'h00, 3'h7, 3'h5);
        arith(CSR_OP_SUB, 8'h05, 8'h05, 8'h00, 3'h7, 3'h7);
        arith(CSR_OP_ROTATE_RIGHT, 8'h00, 8'h01, 8'h80, 3'h1, 3'h1);
        arith(CSR_OP_ROTATE_LEFT, 8'h00, 8'h7f, 8'hff, 3'h1, 3'h0);
        arith(CSR_OP_ROTATE_LEFT, 8'h00, 8'h80, 8'h00, 3'h1, 3'h1);
        arith(CSR_OP_ROTATE_RIGHT, 8'h00, 8'h02, 8'h81, 3'h1, 3'h0);
        u_core.issue(CSR_OP_ROTATE_LEFT, 9'h003, 8'h00, 8'h00, 3'h0);
        check("core_status", core_status, 8'h1e);
        wr(9'h003, 8'h05);
        u_core.issue(CSR_OP_MOVE_FILE, 9'h020, 8'h00, 8'h00, 3'h0);
        u_core.issue(CSR_OP_NIBBLE_SWAP, 9'h020, 8'h00, 8'h00, 3'h0);
        u_core.issue(CSR_OP_BIT_CLEAR, 9'h020, 8'h00, 8'h04, 3'h2);
        u_core.issue(CSR_OP_BIT_SET, 9'h020, 8'h00, 8'h00, 3'h0);
        check("core_status", core_status, 8'h1d);
        u_core.issue(CSR_OP_BIT_SET, 9'h003, 8'h00, 8'h1d, 3'h1);
        check("core_status", core_status, 8'h1f);
        u_core.pulse(5'h04);
        check("core_status", core_status, 8'h0f);
        u_core.pulse(5'h02);
        check("core_status", core_status, 8'h1f);
        u_core.pulse(5'h01);
        check("sleep_bit", {7'h00, core_status[3]}, 8'h00);
        wr(9'h08e, 8'hff);
        rd(9'h08e, 8'h03);
        u_core.pulse(5'h08);
        check("power_flags", power_control_flags, 8'h02);
        check("core_status", core_status, 8'h18);
        wr(9'h08e, 8'h03);
        u_core.pulse(5'h10);
        check("poweron_flag", power_control_flags[1], 8'h00);
        @(posedge clk);
        brownout_detect_enable <= 1'b1;
        @(posedge clk);
        #1;
        check("brownout_valid", brownout_valid, 8'h01);
        close_out();
    end
endmodule
